/* File: hw/flt_pkg.sv */
package flt_pkg;
  // Widths and sizes
  localparam int CODE_W    = 16;
  localparam int VAL_W     = 32;
  localparam int DAYS_W    = 16;
  localparam int MS_W      = 27;
  localparam int CNT_W     = 16;
  localparam int BUF_N     = 8;
  localparam int IDX_W     = 3;
  localparam int HIST_N    = 56;
  localparam int HIST_BASE = 8;
  localparam int RECL_N    = 20;
  localparam int CAT_W     = 2;
  localparam int SRC_W     = 4;
  // Message categories
  localparam logic [CAT_W-1:0] CAT_FAULT = 2'h1;
  localparam logic [CAT_W-1:0] CAT_ALARM = 2'h2;
  localparam logic [CAT_W-1:0] CAT_NONE  = 2'h3;
  // Status and control bit positions
  localparam int STW1_FAULT_BIT = 3;
  localparam int CTW1_ACK_BIT   = 7;
  localparam int DIN_ACK_BIT    = 2;
  // Time base
  localparam int CLK_HZ      = 10_000_000;
  localparam int MS_PER_SEC  = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / MS_PER_SEC;
  localparam logic [MS_W-1:0] MS_PER_DAY = 27'h5265C00;
  localparam logic [MS_W-1:0] MS_RESET   = 27'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h1;
  // One stored fault record
  typedef struct packed {
    logic              used;
    logic              active;
    logic              internal;
    logic [CODE_W-1:0] code;
    logic [VAL_W-1:0]  val_fix;
    logic [VAL_W-1:0]  val_flt;
    logic [DAYS_W-1:0] arr_days;
    logic [MS_W-1:0]   arr_ms;
    logic [DAYS_W-1:0] rem_days;
    logic [MS_W-1:0]   rem_ms;
  } flt_rec_t;
endpackage : flt_pkg

/* File: hw/flt_timebase.sv */
`timescale 1ns/1ns
module flt_timebase
  import flt_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Time outputs
  output logic [DAYS_W-1:0]      days,
  output logic [MS_W-1:0]        ms
);
  logic [$clog2(CYC_PER_MS)-1:0] pre_q, pre_d;
  logic [MS_W-1:0]               ms_q, ms_d;
  logic [DAYS_W-1:0]             days_q, days_d;
  logic                          tick;

  always_comb begin
    tick   = (pre_q == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1));
    pre_d  = tick ? '0 : pre_q + 1'b1;
    ms_d   = ms_q;
    days_d = days_q;
    if (tick) begin
      if (ms_q == MS_PER_DAY - 1'b1) begin
        ms_d   = MS_RESET;
        days_d = days_q + 1'b1;
      end else begin
        ms_d = ms_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pre_q  <= '0;
      ms_q   <= '0;
      days_q <= '0;
    end else begin
      pre_q  <= pre_d;
      ms_q   <= ms_d;
      days_q <= days_d;
    end
  end

  assign days = days_q;
  assign ms   = ms_q;
endmodule : flt_timebase

/* File: hw/flt_reclass.sv */
`timescale 1ns/1ns
module flt_reclass
  import flt_pkg::*;
(
  // Table entries, flattened
  input  wire logic [RECL_N*CODE_W-1:0] reclass_message_number,
  input  wire logic [RECL_N*CAT_W-1:0]  reclass_message_category,
  // Lookup
  input  wire logic [CODE_W-1:0]        msg_code,
  input  wire logic [CAT_W-1:0]         default_cat,
  output logic [CAT_W-1:0]              eff_cat
);
  logic [RECL_N-1:0] hit;

  for (genvar i = 0; i < RECL_N; i++) begin : g_ent
    assign hit[i] = (reclass_message_number[i*CODE_W +: CODE_W] == msg_code) &&
                    (reclass_message_category[i*CAT_W +: CAT_W] != 2'h0);
  end

  always_comb begin
    eff_cat = default_cat;
    for (int i = RECL_N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        eff_cat = reclass_message_category[i*CAT_W +: CAT_W];
      end
    end
  end
endmodule : flt_reclass

/* File: hw/flt_log.sv */
`timescale 1ns/1ns
module flt_log
  import flt_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  // Incoming message, one-cycle strobe
  input  wire logic                     msg_valid,
  input  wire logic [CODE_W-1:0]        msg_code,
  input  wire logic                     msg_is_fault,
  input  wire logic                     msg_internal,
  input  wire logic [VAL_W-1:0]         msg_val_fix,
  input  wire logic [VAL_W-1:0]         msg_val_flt,
  input  wire logic                     msg_new_case,
  // Cause cleared, one-cycle strobe per code
  input  wire logic                     cause_gone_valid,
  input  wire logic [CODE_W-1:0]        cause_gone_code,
  // Acknowledge sources
  input  wire logic                     power_on_ack,
  input  wire logic                     panel_ack_key,
  input  wire logic [SRC_W-1:0]         digital_in,
  input  wire logic [CNT_W-1:0]         control_word_one,
  // Reclassification table
  input  wire logic [RECL_N*CODE_W-1:0] reclass_message_number,
  input  wire logic [RECL_N*CAT_W-1:0]  reclass_message_category,
  // Fault-case counter write
  input  wire logic                     case_cnt_wr,
  input  wire logic [CNT_W-1:0]         case_cnt_wdata,
  // Status
  output logic [CNT_W-1:0]              status_word_one,
  output logic                          fault_present,
  output logic                          ready_led_red,
  output logic [CNT_W-1:0]              fault_case_counter,
  output logic [CODE_W-1:0]             current_fault_code,
  output logic                          alarm_out_valid,
  output logic [CODE_W-1:0]             alarm_out_code,
  // Buffer read port
  input  wire logic [IDX_W-1:0]         buf_rd_idx,
  output logic [CODE_W-1:0]             fault_code_slots,
  output logic [VAL_W-1:0]              fault_value_fixed,
  output logic [VAL_W-1:0]              fault_value_float,
  output logic [DAYS_W-1:0]             fault_arrival_days,
  output logic [MS_W-1:0]               fault_arrival_ms,
  output logic [DAYS_W-1:0]             fault_removal_days,
  output logic [MS_W-1:0]               fault_removal_ms,
  output logic                          buf_rd_used,
  // History read port, index 8..63
  input  wire logic [5:0]               hist_rd_idx,
  output logic [CODE_W-1:0]             hist_code,
  output logic [DAYS_W-1:0]             hist_arrival_days,
  output logic [MS_W-1:0]               hist_arrival_ms,
  output logic [DAYS_W-1:0]             hist_removal_days,
  output logic [MS_W-1:0]               hist_removal_ms,
  output logic                          hist_used
);
  flt_rec_t              buf_q  [BUF_N];
  flt_rec_t              buf_d  [BUF_N];
  flt_rec_t              hist_q [HIST_N];
  flt_rec_t              hist_d [HIST_N];
  flt_rec_t              new_rec;
  flt_rec_t              rd_rec;
  flt_rec_t              hrd_rec;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic [DAYS_W-1:0]     now_days;
  logic [MS_W-1:0]       now_ms;
  logic [CAT_W-1:0]      eff_cat;
  logic [BUF_N-1:0]      used_v, gone_v;
  logic                  ack_ext, ack_any, ack_eff;
  logic [IDX_W:0]        fill;
  logic [IDX_W:0]        wr;
  logic                  rec_fault;
  logic [CODE_W-1:0]     cur_code;
  logic                  any_fault;
  logic [5:0]            hidx;

  flt_timebase u_tb (
    .mclk (mclk),
    .nrst (nrst),
    .days (now_days),
    .ms   (now_ms)
  );

  flt_reclass u_rc (
    .reclass_message_number   (reclass_message_number),
    .reclass_message_category (reclass_message_category),
    .msg_code                 (msg_code),
    .default_cat              (msg_is_fault ? CAT_FAULT : CAT_ALARM),
    .eff_cat                  (eff_cat)
  );

  assign rec_fault = msg_valid && (eff_cat == CAT_FAULT);

  always_comb begin
    alarm_out_valid = msg_valid && (eff_cat == CAT_ALARM);
    alarm_out_code  = msg_code;
  end

  for (genvar i = 0; i < BUF_N; i++) begin : g_flag
    assign used_v[i] = buf_q[i].used;
    assign gone_v[i] = buf_q[i].used && !buf_q[i].active;
  end

  assign ack_ext = panel_ack_key || digital_in[DIN_ACK_BIT] ||
                   control_word_one[CTW1_ACK_BIT];
  assign ack_any = ack_ext || power_on_ack;
  // needs at least one gone cause
  assign ack_eff = ack_any && (|gone_v);

  always_comb begin
    fill = '0;
    for (int i = 0; i < BUF_N; i++) begin
      if (used_v[i]) begin
        fill = fill + 1'b1;
      end
    end
  end

  always_comb begin
    new_rec          = '0;
    new_rec.used     = 1'b1;
    new_rec.active   = 1'b1;
    new_rec.internal = msg_internal;
    new_rec.code     = msg_code;
    new_rec.val_fix  = msg_val_fix;
    new_rec.val_flt  = msg_val_flt;
    new_rec.arr_days = now_days;
    new_rec.arr_ms   = now_ms;
  end

  // Buffer and history next state
  always_comb begin
    for (int i = 0; i < BUF_N; i++) begin
      buf_d[i] = buf_q[i];
    end
    for (int h = 0; h < HIST_N; h++) begin
      hist_d[h] = hist_q[h];
    end
    cnt_d = cnt_q;
    wr    = '0;
    // Cause removal marks the entry gone; internal ones only when power_on_ack comes with it
    for (int i = 0; i < BUF_N; i++) begin
      if (cause_gone_valid && buf_q[i].used && buf_q[i].code == cause_gone_code &&
          (!buf_q[i].internal || power_on_ack)) begin
        buf_d[i].active = 1'b0;
      end
    end
    if (ack_eff) begin
      for (int h = HIST_N - 1; h >= BUF_N; h--) begin
        hist_d[h] = hist_q[h - BUF_N];
      end
      for (int i = 0; i < BUF_N; i++) begin
        hist_d[i] = buf_q[i];
        if (gone_v[i]) begin
          hist_d[i].rem_days = now_days;
          hist_d[i].rem_ms   = now_ms;
        end
      end
      for (int i = 0; i < BUF_N; i++) begin
        buf_d[i] = '0;
      end
      for (int i = 0; i < BUF_N; i++) begin
        if (buf_q[i].used && buf_q[i].active) begin
          buf_d[wr[IDX_W-1:0]] = buf_q[i];
          wr = wr + 1'b1;
        end
      end
      cnt_d = CNT_ZERO;
    end
    if (rec_fault) begin
      if (msg_new_case || cnt_d == CNT_ZERO) begin
        cnt_d = cnt_d + CNT_ONE;
      end
      if (ack_eff) begin
        if (wr < (IDX_W+1)'(BUF_N)) begin
          buf_d[wr[IDX_W-1:0]] = new_rec;
        end else begin
          buf_d[BUF_N-2] = new_rec;
        end
      end else if (fill < (IDX_W+1)'(BUF_N)) begin
        buf_d[fill[IDX_W-1:0]] = new_rec;
      end else begin
        buf_d[BUF_N-2] = new_rec;
      end
    end
    if (case_cnt_wr) begin
      cnt_d = case_cnt_wdata;
      if (case_cnt_wdata == CNT_ZERO) begin
        for (int i = 0; i < BUF_N; i++) begin
          buf_d[i] = '0;
        end
        for (int h = 0; h < HIST_N; h++) begin
          hist_d[h] = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < BUF_N; i++) begin
        buf_q[i] <= '0;
      end
      for (int h = 0; h < HIST_N; h++) begin
        hist_q[h] <= '0;
      end
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < BUF_N; i++) begin
        buf_q[i] <= buf_d[i];
      end
      for (int h = 0; h < HIST_N; h++) begin
        hist_q[h] <= hist_d[h];
      end
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    cur_code  = '0;
    any_fault = 1'b0;
    for (int i = BUF_N - 1; i >= 0; i--) begin
      if (buf_q[i].used && buf_q[i].active) begin
        cur_code  = buf_q[i].code;
        any_fault = 1'b1;
      end
    end
  end

  // Read ports
  always_comb begin
    rd_rec  = buf_q[buf_rd_idx];
    hidx    = hist_rd_idx - 6'(HIST_BASE);
    hrd_rec = (hist_rd_idx >= 6'(HIST_BASE)) ? hist_q[hidx] : '0;
  end

  always_comb begin
    fault_code_slots   = rd_rec.code;
    fault_value_fixed  = rd_rec.val_fix;
    fault_value_float  = rd_rec.val_flt;
    fault_arrival_days = rd_rec.arr_days;
    fault_arrival_ms   = rd_rec.arr_ms;
    fault_removal_days = rd_rec.rem_days;
    fault_removal_ms   = rd_rec.rem_ms;
    buf_rd_used        = rd_rec.used;
    hist_code          = hrd_rec.code;
    hist_arrival_days  = hrd_rec.arr_days;
    hist_arrival_ms    = hrd_rec.arr_ms;
    hist_removal_days  = hrd_rec.rem_days;
    hist_removal_ms    = hrd_rec.rem_ms;
    hist_used          = hrd_rec.used;
  end

  always_comb begin
    status_word_one                 = '0;
    status_word_one[STW1_FAULT_BIT] = any_fault;
  end
  assign fault_present      = any_fault;
  assign ready_led_red      = any_fault;
  assign fault_case_counter = cnt_q;
  assign current_fault_code = cur_code;
endmodule : flt_log

/* File: verif/flt_log_monitor.sv */
`timescale 1ns/1ns
module flt_log_chk
  import flt_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              nrst,
  // Stimulus
  input wire logic              msg_valid,
  input wire logic [CODE_W-1:0] msg_code,
  input wire logic              power_on_ack,
  input wire logic              panel_ack_key,
  input wire logic [SRC_W-1:0]  digital_in,
  input wire logic [CNT_W-1:0]  control_word_one,
  input wire logic              case_cnt_wr,
  input wire logic [CNT_W-1:0]  case_cnt_wdata,
  input wire logic [IDX_W-1:0]  buf_rd_idx,
  input wire logic [5:0]        hist_rd_idx,
  // Results
  input wire logic [CNT_W-1:0]  status_word_one,
  input wire logic              fault_present,
  input wire logic              ready_led_red,
  input wire logic [CNT_W-1:0]  fault_case_counter,
  input wire logic              alarm_out_valid,
  input wire logic [CODE_W-1:0] alarm_out_code,
  input wire logic [MS_W-1:0]   fault_removal_ms,
  input wire logic [CODE_W-1:0] hist_code,
  input wire logic              hist_used
);
  logic ack_any;
  assign ack_any = power_on_ack | panel_ack_key | digital_in[DIN_ACK_BIT]
                 | control_word_one[CTW1_ACK_BIT];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  fault_flag_a: assert property (fault_present |-> status_word_one[STW1_FAULT_BIT]
    && ready_led_red) else $error("fault flags disagree");
  fault_rise_a: assert property ($rose(fault_present) |-> $past(msg_valid))
    else $error("fault shown without a message");
  zero_write_a: assert property (case_cnt_wr && case_cnt_wdata == CNT_ZERO
    |=> fault_case_counter == CNT_ZERO && !fault_present) else $error("zero write kept faults");
  count_hold_a: assert property (!ack_any && !case_cnt_wr
    |=> fault_case_counter >= $past(fault_case_counter)) else $error("counter fell");
  alarm_pass_a: assert property (alarm_out_valid |-> msg_valid
    && alarm_out_code == msg_code) else $error("alarm out without message");
  hist_low_a: assert property (hist_rd_idx < 6'h08 |-> !hist_used
    && hist_code == '0) else $error("history below base not empty");
  reset_clear_a: assert property ($rose(nrst) |-> fault_case_counter == CNT_ZERO
    && !fault_present) else $error("state not cleared by reset");
  removal_hold_a: assert property (!ack_any && !case_cnt_wr ##1 $stable(buf_rd_idx)
    |-> fault_removal_ms == '0 || $stable(fault_removal_ms)) else $error("removal set early");
  hist_hold_a: assert property (!ack_any && !case_cnt_wr ##1 $stable(hist_rd_idx)
    |-> $stable(hist_code)) else $error("history moved without ack");
endmodule : flt_log_chk

bind flt_log flt_log_chk chk (.*);

/* File: verif/flt_ack_src.sv */
`timescale 1ns/1ns
module flt_ack_src
  import flt_pkg::*;
(
  // Request from bench
  input wire logic [1:0]        sel,
  input wire logic              go,
  // Panel, terminal and fieldbus
  output logic                  panel_ack_key,
  output logic [SRC_W-1:0]      digital_in,
  output logic [CNT_W-1:0]      control_word_one
);
  // three external sources
  // Neighbour bits busy, so only the ack bit may count
  assign panel_ack_key    = go && sel == 2'h0;
  assign digital_in       = {1'b1, go && sel == 2'h1, 2'h1};
  assign control_word_one = {8'h5A, go && sel == 2'h2, 7'h25};
endmodule : flt_ack_src

/* File: verif/test_flt_log.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module test_flt_log
  import flt_pkg::*;
;
  logic                     mclk = 1'b0, nrst = 1'b0, go = 1'b0, power_on_ack = 1'b0;
  logic                     msg_valid = 1'b0, msg_is_fault = 1'b0, msg_internal = 1'b0;
  logic                     msg_new_case = 1'b0, cause_gone_valid = 1'b0, case_cnt_wr = 1'b0;
  logic [1:0]               sel = 2'h0;
  logic [CODE_W-1:0]        msg_code = '0, cause_gone_code = '0;
  logic [VAL_W-1:0]         msg_val_fix = '0, msg_val_flt = '0;
  logic [RECL_N*CODE_W-1:0] reclass_message_number = '0;
  logic [RECL_N*CAT_W-1:0]  reclass_message_category = '0;
  logic [CNT_W-1:0]         case_cnt_wdata = '0;
  logic [IDX_W-1:0]         buf_rd_idx = '0;
  logic [5:0]               hist_rd_idx = '0;
  logic [16:0]              al;
  int                       bad_count = 0, n_tests = 0;
  logic [CNT_W-1:0]         status_word_one, fault_case_counter, control_word_one;
  logic [CODE_W-1:0]        current_fault_code, alarm_out_code, fault_code_slots, hist_code;
  logic [VAL_W-1:0]         fault_value_fixed, fault_value_float;
  logic [DAYS_W-1:0]        fault_arrival_days, fault_removal_days;
  logic [DAYS_W-1:0]        hist_arrival_days, hist_removal_days, hist_arrival_ms_hi;
  logic [MS_W-1:0]          fault_arrival_ms, fault_removal_ms, hist_removal_ms, hist_arrival_ms;
  logic [SRC_W-1:0]         digital_in;
  logic                     fault_present, ready_led_red, alarm_out_valid, buf_rd_used;
  logic                     hist_used, panel_ack_key;

  flt_log uut (.*);
  flt_ack_src pnl (.*);

  always #50 mclk = ~mclk;

  task automatic msg(input logic [CODE_W-1:0] c, input logic f, i, n);
    @(negedge mclk);
    {msg_valid, msg_code, msg_is_fault, msg_internal, msg_new_case} = {1'b1, c, f, i, n};
    msg_val_fix = {16'h0, c};
    msg_val_flt = {c, 16'h0};
    #1 al = {alarm_out_valid, alarm_out_code};
    @(negedge mclk);
    msg_valid = 1'b0;
  endtask : msg

  task automatic gone(input logic [CODE_W-1:0] c, input logic p);
    @(negedge mclk);
    {cause_gone_valid, cause_gone_code, power_on_ack} = {1'b1, c, p};
    @(negedge mclk);
    {cause_gone_valid, power_on_ack} = 2'b00;
  endtask : gone

  task automatic ack(input logic [1:0] s);
    @(negedge mclk);
    {sel, go} = {s, 1'b1};
    @(negedge mclk);
    go = 1'b0;
  endtask : ack

  task automatic rd(input logic [IDX_W-1:0] b, input logic [5:0] h);
    @(negedge mclk);
    {buf_rd_idx, hist_rd_idx} = {b, h};
    #1;
  endtask : rd

  task automatic s_one;
    msg(16'h5, 1'b1, 1'b0, 1'b1);
    rd(3'h0, 6'h08);
    `CHK(fault_code_slots, 16'h5)
    `CHK({fault_value_fixed, fault_value_float}, {32'h5, 32'h50000})
    `CHK({fault_arrival_days, fault_arrival_ms}, 43'h0)
    `CHK({status_word_one[STW1_FAULT_BIT], ready_led_red, fault_present}, 3'h7)
    `CHK({current_fault_code, fault_case_counter}, {16'h5, 16'h1})
    ack(2'h0);
    rd(3'h0, 6'h08);
    `CHK({buf_rd_used, hist_used, fault_case_counter}, {2'b10, 16'h1})
    gone(16'h5, 1'b0);
    repeat (CYC_PER_MS + 1) @(negedge mclk);
    ack(2'h1);
    rd(3'h0, 6'h08);
    `CHK({buf_rd_used, hist_used, hist_code, fault_case_counter}, {2'b01, 16'h5, 16'h0})
    `CHK({hist_removal_ms > 0, fault_present}, 2'b10)
    `CHK({hist_arrival_days, hist_arrival_ms, hist_removal_days}, 59'h0)
  endtask : s_one

  task automatic s_eight;
    for (int k = 0; k < 9; k++) msg(CODE_W'(16'h101 + k), 1'b1, k == 0, k == 0);
    for (int k = 0; k < 8; k++) begin
      rd(IDX_W'(k), 6'h08);
      `CHK(fault_code_slots, CODE_W'(k < 6 ? 16'h101 + k : 16'h10F - k))
    end
    `CHK(fault_case_counter, 16'h1)
    gone(16'h101, 1'b0);
    gone(16'h102, 1'b0);
    ack(2'h2);
    rd(3'h0, 6'h08);
    `CHK({fault_code_slots, hist_code, hist_removal_ms}, {16'h101, 16'h101, 27'h0})
    `CHK({fault_removal_days, fault_removal_ms}, 43'h0)
    `CHK(current_fault_code, 16'h101)
    rd(3'h1, 6'h09);
    `CHK({fault_code_slots, hist_code}, {16'h103, 16'h102})
    rd(3'h7, 6'h10);
    `CHK({buf_rd_used, hist_code}, {1'b0, 16'h5})
    gone(16'h103, 1'b0);
    ack(2'h0);
    rd(3'h0, 6'h0F);
    `CHK(hist_used, 1'b0)
    rd(3'h0, 6'h18);
    `CHK(hist_code, 16'h5)
    gone(16'h101, 1'b1);
    ack(2'h1);
    `CHK(current_fault_code, 16'h104)
  endtask : s_eight

  task automatic s_zero;
    @(negedge mclk);
    {case_cnt_wr, case_cnt_wdata} = {1'b1, CNT_ZERO};
    @(negedge mclk);
    case_cnt_wr = 1'b0;
    rd(3'h0, 6'h10);
    `CHK({fault_case_counter, buf_rd_used, hist_used, fault_present}, 19'h0)
  endtask : s_zero

  task automatic s_recl;
    @(negedge mclk);
    reclass_message_number[0+:16]    = 16'h201;
    reclass_message_category[0+:2]   = CAT_ALARM;
    reclass_message_number[16+:16]   = 16'h202;
    reclass_message_category[2+:2]   = CAT_FAULT;
    reclass_message_number[304+:16]  = 16'h200;
    reclass_message_category[38+:2]  = CAT_NONE;
    msg(16'h201, 1'b1, 1'b0, 1'b1);
    `CHK(al, {1'b1, 16'h201})
    msg(16'h200, 1'b1, 1'b0, 1'b1);
    `CHK(al, {1'b0, 16'h200})
    msg(16'h202, 1'b0, 1'b0, 1'b1);
    rd(3'h0, 6'h08);
    `CHK({buf_rd_used, fault_code_slots, fault_case_counter}, {1'b1, 16'h202, 16'h1})
  endtask : s_recl

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    s_one;
    s_eight;
    s_zero;
    s_recl;
    tally_and_finish;
  end
endmodule : test_flt_log
